// ---- verilog/sswa_core.sv ----
/*
 * Serial shift, wait and acknowledge block with an Avalon-MM slave.
 * Assumes ref_clk at 25 MHz, the serial clock and data arriving as
 * asynchronous pins, and software keeping to the buffer access limits.
 */
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
// Function
// - Eight-bit shift register drives its top bit out after each clock fall.
// - Each clock rise samples the data pin into the bottom bit, shifting up.
// - Software loads and reads the shifter only through the data buffer.
// - Wait control bits 0 and 1 select the pause condition.
// - Writing 1 to bit 2 releases the wait and starts communication.
// - Bit 2 reads 0 while paused and 1 while communicating.
// - Writing 0 to bit 2 while running forces an immediate wait.
// - Bit 3 is the acknowledge: written for output, read for input.
// - Clock counter counts rises from 0, wraps after 9 bus, 8 serial.
module sswa_core (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    input  wire logic [sswa_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [sswa_pkg::DATA_W-1:0]  avs_writedata,
    output logic      [sswa_pkg::DATA_W-1:0]  avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         scl_in,
    output logic                              scl_out,
    output logic                              scl_oe,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe
);

    typedef struct packed {
        sswa_pkg::sswa_bus_st_t        bus;
        logic                          waitreq;
        logic [sswa_pkg::DATA_W-1:0]   rdata;
        logic [1:0]                    wait_sel;
        logic                          running;
        logic                          ack;
        logic                          bus_mode;
        logic                          tx_dir;
        logic                          hold_scl;
        logic                          started;
        logic [sswa_pkg::CNT_W-1:0]    count;
        logic                          scl_prev;
        logic                          sda_prev;
        sswa_pkg::sswa_pin_drv_t       sda_drv;
        sswa_pkg::sswa_pin_drv_t       scl_drv;
    } sswa_core_st_t;

    sswa_core_st_t                 st_reg;
    sswa_core_st_t                 st_next;
    sswa_pkg::sswa_avs_req_t       req;
    logic                          scl_lvl;
    logic                          sda_lvl;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          sda_fall;
    logic                          sr_load;
    logic                          sr_shift;
    logic [sswa_pkg::SR_W-1:0]     sr_data;
    logic [3:0]                    waitack_view;

    // Wrap point of the clock counter depends on the mode
    function automatic logic [sswa_pkg::CNT_W-1:0] cnt_top(input logic bus_mode);
        cnt_top = bus_mode ? sswa_pkg::CNT_BUS_TOP : sswa_pkg::CNT_SER_TOP;
    endfunction : cnt_top

    // Decide whether a clock fall at this count matches the wait code
    function automatic logic wait_hit(
        input logic [1:0]                 sel,
        input logic [sswa_pkg::CNT_W-1:0] cnt,
        input logic                       bus_mode,
        input logic                       started
    );
        case (sswa_pkg::sswa_wait_t'(sel))
            sswa_pkg::SSWA_WAIT_DATA: wait_hit = (cnt == sswa_pkg::CNT_BYTE);
            sswa_pkg::SSWA_WAIT_ACK:  wait_hit = bus_mode && (cnt == sswa_pkg::CNT_BUS_TOP);
            sswa_pkg::SSWA_WAIT_ADDR: wait_hit = started && (cnt == sswa_pkg::CNT_BYTE);
            default:                  wait_hit = 1'b0;
        endcase
    endfunction : wait_hit

    assign req.address   = avs_address;
    assign req.read      = avs_read;
    assign req.write     = avs_write;
    assign req.writedata = avs_writedata;

    // Pins from outside pass the three-stage filter before edge detection
    sswa_sync u_scl_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (scl_in),
        .level    (scl_lvl)
    );

    sswa_sync u_sda_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (sda_in),
        .level    (sda_lvl)
    );

    // Edges of the filtered lines
    assign scl_rise = scl_lvl && !st_reg.scl_prev;
    assign scl_fall = !scl_lvl && st_reg.scl_prev;
    assign sda_fall = !sda_lvl && st_reg.sda_prev && scl_lvl;

    // Buffer write presets the shifter; no other register write reaches its bits
    assign sr_load  = (st_reg.bus == sswa_pkg::SSWA_BUS_IDLE) && req.write
                      && (req.address == sswa_pkg::IDX_BUFFER);
    assign sr_shift = st_reg.running && scl_rise;

    sswa_shift u_shift (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .load      (sr_load),
        .load_data (req.writedata[sswa_pkg::SR_W-1:0]),
        .shift     (sr_shift),
        .serial_in (sda_lvl),
        .data      (sr_data)
    );

    // Software view of the wait and acknowledge register
    assign waitack_view = {st_reg.ack, st_reg.running, st_reg.wait_sel};

    always_comb begin
        st_next          = st_reg;
        st_next.scl_prev = scl_lvl;
        st_next.sda_prev = sda_lvl;

        // Start condition: data falls while clock is high, counter restarts
        if (st_reg.bus_mode && sda_fall) begin
            st_next.started = 1'b1;
            st_next.count   = sswa_pkg::CNT_ZERO;
        end

        // Clock counter counts every rise of the clock pin, wraps per mode
        if (scl_rise) begin
            if (st_reg.count >= cnt_top(st_reg.bus_mode)) begin
                st_next.count = sswa_pkg::CNT_ZERO;
            end else begin
                st_next.count = st_reg.count + 4'h1;
            end
        end

        // On the falling clock present the next bit, and also pause if the wait code matches
        if (st_reg.running && scl_fall) begin
            if (wait_hit(st_reg.wait_sel, st_reg.count, st_reg.bus_mode,
                         st_reg.started)) begin
                st_next.running  = 1'b0;
                st_next.hold_scl = 1'b1;
                if (sswa_pkg::sswa_wait_t'(st_reg.wait_sel) == sswa_pkg::SSWA_WAIT_ADDR) begin
                    st_next.started = 1'b0;
                end
            end
            if (st_reg.bus_mode && (st_reg.count == sswa_pkg::CNT_BYTE)) begin
                // Ninth clock: receiver drives ack, transmitter lets go
                st_next.sda_drv.out = 1'b0;
                st_next.sda_drv.oe  = !st_reg.tx_dir && !st_reg.ack;
            end else if (st_reg.tx_dir) begin
                st_next.sda_drv.out = st_reg.bus_mode ? 1'b0 : sr_data[sswa_pkg::SR_W-1];
                st_next.sda_drv.oe  = st_reg.bus_mode ? !sr_data[sswa_pkg::SR_W-1]
                                                      : 1'b1;
            end else begin
                st_next.sda_drv.out = 1'b0;
                st_next.sda_drv.oe  = 1'b0;
            end
        end

        // Avalon slave: answer one cycle after the request appears
        case (st_reg.bus)
            sswa_pkg::SSWA_BUS_IDLE: begin
                if (req.read || req.write) begin
                    st_next.bus     = sswa_pkg::SSWA_BUS_ANSWER;
                    st_next.waitreq = 1'b0;
                    st_next.rdata   = '0;
                    if (req.read) begin
                        case (req.address)
                            sswa_pkg::IDX_BUFFER: begin
                                st_next.rdata[sswa_pkg::SR_W-1:0] = sr_data;
                            end
                            sswa_pkg::IDX_CONFIG: begin
                                st_next.rdata[sswa_pkg::CFG_BUS_MODE] = st_reg.bus_mode;
                                st_next.rdata[sswa_pkg::CFG_TX_DIR]   = st_reg.tx_dir;
                            end
                            sswa_pkg::IDX_STATUS: begin
                                st_next.rdata[sswa_pkg::CNT_W-1:0] = st_reg.count;
                            end
                            sswa_pkg::IDX_WAITACK: begin
                                st_next.rdata[3:0] = waitack_view;
                            end
                            default: begin
                                st_next.rdata = '0;
                            end
                        endcase
                    end else begin
                        case (req.address)
                            sswa_pkg::IDX_CONFIG: begin
                                st_next.bus_mode = req.writedata[sswa_pkg::CFG_BUS_MODE];
                                st_next.tx_dir   = req.writedata[sswa_pkg::CFG_TX_DIR];
                            end
                            sswa_pkg::IDX_WAITACK: begin
                                st_next.wait_sel = req.writedata[sswa_pkg::WC_HI:sswa_pkg::WC_LO];
                                st_next.ack      = req.writedata[sswa_pkg::WC_ACK];
                                if (req.writedata[sswa_pkg::WC_RELEASE]) begin
                                    st_next.running  = 1'b1;
                                    st_next.hold_scl = 1'b0;
                                end else if (st_reg.running) begin
                                    st_next.running  = 1'b0;
                                    st_next.hold_scl = 1'b1;
                                end
                            end
                            default: begin
                                st_next.bus_mode = st_reg.bus_mode;
                            end
                        endcase
                    end
                end
            end
            sswa_pkg::SSWA_BUS_ANSWER: begin
                st_next.bus     = sswa_pkg::SSWA_BUS_IDLE;
                st_next.waitreq = 1'b1;
            end
            default: begin
                st_next.bus     = sswa_pkg::SSWA_BUS_IDLE;
                st_next.waitreq = 1'b1;
            end
        endcase

        // Transmitter captures peer's ack on the ninth rise; beats a software write
        if (st_reg.running && scl_rise && st_reg.bus_mode && st_reg.tx_dir
            && (st_reg.count == sswa_pkg::CNT_BYTE)) begin
            st_next.ack = sda_lvl;
        end

        // Serial clock line pulled low only while paused
        st_next.scl_drv.out = 1'b0;
        st_next.scl_drv.oe  = st_next.hold_scl;
    end

    // Whole state resets to idle; wait register to its cleared value
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg          <= '0;
            st_reg.bus      <= sswa_pkg::SSWA_BUS_IDLE;
            st_reg.waitreq  <= 1'b1;
            st_reg.wait_sel <= sswa_pkg::WAITACK_RST[sswa_pkg::WC_HI:sswa_pkg::WC_LO];
            st_reg.running  <= sswa_pkg::WAITACK_RST[sswa_pkg::WC_RELEASE];
            st_reg.ack      <= sswa_pkg::WAITACK_RST[sswa_pkg::WC_ACK];
            st_reg.scl_prev <= 1'b1;
            st_reg.sda_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output comes straight from the state register
    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign scl_out         = st_reg.scl_drv.out;
    assign scl_oe          = st_reg.scl_drv.oe;
    assign sda_out         = st_reg.sda_drv.out;
    assign sda_oe          = st_reg.sda_drv.oe;

endmodule : sswa_core

// ---- verilog/sswa_pkg.sv ----
/*
 * Package for the serial shift, wait and acknowledge block: register
 * indices, field positions, reset values, codes and packed carriers.
 * Assumes a 32-bit Avalon-MM slave with word addressing.
 */
package sswa_pkg;

    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam int          SR_W         = 8;
    localparam int          CNT_W        = 4;

    // Register word indices; byte address is four times the index
    localparam logic [3:0]  IDX_BUFFER   = 4'h0;
    localparam logic [3:0]  IDX_CONFIG   = 4'h1;
    localparam logic [3:0]  IDX_STATUS   = 4'h2;
    localparam logic [3:0]  IDX_WAITACK  = 4'hE;

    // Wait and acknowledge control fields
    localparam int          WC_LO        = 0;
    localparam int          WC_HI        = 1;
    localparam int          WC_RELEASE   = 2;
    localparam int          WC_ACK       = 3;
    localparam logic [3:0]  WAITACK_RST  = 4'h0;

    // Configuration fields
    localparam int          CFG_BUS_MODE = 0;
    localparam int          CFG_TX_DIR   = 1;

    // Clock counter figures
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_BYTE     = 4'h8;
    localparam logic [3:0]  CNT_BUS_TOP  = 4'h9;
    localparam logic [3:0]  CNT_SER_TOP  = 4'h8;

    typedef enum logic [1:0] {
        SSWA_WAIT_NONE,
        SSWA_WAIT_DATA,
        SSWA_WAIT_ACK,
        SSWA_WAIT_ADDR
    } sswa_wait_t;

    typedef enum {
        SSWA_BUS_IDLE,
        SSWA_BUS_ANSWER
    } sswa_bus_st_t;

    // Avalon-MM request as seen by the slave
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
    } sswa_avs_req_t;

    // Open-drain or push-pull pin: level out and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } sswa_pin_drv_t;

endpackage : sswa_pkg

// ---- verilog/sswa_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to ref_clk; the filtered level
 * moves only when the second and third stages agree.
 */
`timescale 1ns/1ns
module sswa_sync (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sswa_sync_st_t;

    sswa_sync_st_t st_reg;
    sswa_sync_st_t st_next;

    // First stage feeds only the second; filter looks at stages two and three
    always_comb begin
        st_next     = st_reg;
        st_next.s1  = async_in;
        st_next.s2  = st_reg.s1;
        st_next.s3  = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.lvl = st_reg.s3;
        end
    end

    // Idle bus lines rest high, so reset to high
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.lvl;

endmodule : sswa_sync

// ---- verilog/sswa_shift.sv ----
/*
 * Eight-bit presettable shift register.
 * Assumes load and shift are one-cycle strobes in the ref_clk domain;
 * load wins if both arrive together.
 */
`timescale 1ns/1ns
module sswa_shift (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     load,
    input  wire logic [sswa_pkg::SR_W-1:0] load_data,
    input  wire logic                     shift,
    input  wire logic                     serial_in,
    output logic      [sswa_pkg::SR_W-1:0] data
);

    typedef struct packed {
        logic [sswa_pkg::SR_W-1:0] sr;
    } sswa_shift_st_t;

    sswa_shift_st_t st_reg;
    sswa_shift_st_t st_next;

    // Preset from buffer, else shift upward with new bit in the bottom
    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.sr = load_data;
        end else if (shift) begin
            st_next.sr = {st_reg.sr[sswa_pkg::SR_W-2:0], serial_in};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign data = st_reg.sr;

endmodule : sswa_shift

// ---- tb/sswa_core_properties.sv ----
/* Checker for the serial shift, wait and acknowledge core: bus answer
   timing, readback shape and clock-line drive. Sees only the core's
   ports; bound to every core instance at the foot of this file. */
`timescale 1ns/1ns
module sswa_core_properties (
    input wire logic                         ref_clk,
    input wire logic                         rst_b,
    input wire logic [sswa_pkg::ADDR_W-1:0]  avs_address,
    input wire logic                         avs_read,
    input wire logic                         avs_write,
    input wire logic [sswa_pkg::DATA_W-1:0]  avs_writedata,
    input wire logic [sswa_pkg::DATA_W-1:0]  avs_readdata,
    input wire logic                         avs_waitrequest,
    input wire logic                         scl_out,
    input wire logic                         scl_oe
);
    default clocking cb_main @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // An idle request is answered at the very next edge, for one cycle
    property p_answer_next;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer_next: assert property (p_answer_next) else $error("answer late");
    property p_answer_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_answer_one: assert property (p_answer_one) else $error("answer too long");
    property p_answer_cause;
        !avs_waitrequest |-> $past(avs_read || avs_write);
    endproperty
    a_answer_cause: assert property (p_answer_cause) else $error("answer unasked");
    // Read data must not drift between answers
    property p_readdata_hold;
        avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
    endproperty
    a_readdata_hold: assert property (p_readdata_hold) else $error("readdata moved");
    property p_upper_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    // Counter never passes the bus-mode top
    property p_count_range;
        avs_read && !avs_waitrequest && avs_address == sswa_pkg::IDX_STATUS
            |-> avs_readdata[3:0] <= sswa_pkg::CNT_BUS_TOP;
    endproperty
    a_count_range: assert property (p_count_range) else $error("count too big");
    // Open drain: the clock pin is only ever pulled low
    property p_scl_open_drain;
        scl_out == 1'b0;
    endproperty
    a_scl_open_drain: assert property (p_scl_open_drain) else $error("clock driven high");
    property p_release_frees;
        avs_write && !avs_waitrequest && avs_address == sswa_pkg::IDX_WAITACK
            && avs_writedata[sswa_pkg::WC_RELEASE] |-> ##[0:2] !scl_oe;
    endproperty
    a_release_frees: assert property (p_release_frees) else $error("clock still held");
    // A held clock means paused, so the release bit reads 0
    property p_paused_reads;
        avs_read && !avs_waitrequest && avs_address == sswa_pkg::IDX_WAITACK
            && scl_oe && $past(scl_oe) |-> !avs_readdata[sswa_pkg::WC_RELEASE];
    endproperty
    a_paused_reads: assert property (p_paused_reads) else $error("paused reads 1");
endmodule : sswa_core_properties

bind sswa_core sswa_core_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_out(scl_out), .scl_oe(scl_oe));

// ---- tb/sswa_peer.sv ----
/* Peer model: a clocked serial or two-wire master that makes the link
   clock, sends bits MSB first and samples the data line at each high.
   Assumes the bench resolves the wired pins; both idle high. */
`timescale 1ns/1ns
module sswa_peer (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_drv
);
    // Same 320 ns period, but a long low phase: the core's filtered edge
    // path needs about five clocks to present data after a fall
    localparam int HALF = 160;
    localparam int LOW  = 240;
    localparam int HIGH = 80;
    // Lines released between frames; the clock stands still
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task frame(input logic [8:0] tx, input int n, input logic st, output logic [8:0] rx);
        int i;
        int k;
        rx = 9'h000;
        #7;
        // Start: data falls while the clock is high
        if (st) begin
            sda_drv = 1'b0;
            #HALF;
        end
        for (i = n - 1; i >= 0; i--) begin
            scl_drv = 1'b0;
            #(LOW / 2);
            sda_drv = tx[i];
            #(LOW / 2);
            scl_drv = 1'b1;
            k = 0;
            // Stretching: a held clock delays the high phase, bounded
            while (scl_line !== 1'b1 && k < 20) begin
                #40;
                k++;
            end
            #(HIGH - 10);
            rx = {rx[7:0], sda_line};
            #10;
        end
        // Closing fall, then release; a paused device keeps the clock low
        scl_drv = 1'b0;
        #LOW;
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    endtask : frame
endmodule : sswa_peer

// ---- tb/testbench.sv ----
/* Bench for the serial shift, wait and acknowledge core: Avalon tasks,
   one serial frame per case and register checks. Assumes the peer
   model is driven through its frame task. */
`timescale 1ns/1ns
module testbench;
    logic        ref_clk, rst_b, avs_read, avs_write;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe;
    logic        scl_drv, sda_drv;
    logic [8:0]  prx;
    int          fail_count, checks, cyc;
    // Wired pins: device pulls the clock low, drives data when enabled
    wire logic scl_line = scl_oe ? (scl_out & scl_drv) : scl_drv;
    wire logic sda_line = sda_oe ? sda_out : sda_drv;

    sswa_core u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
    sswa_peer u_peer (.scl_line(scl_line), .sda_line(sda_line),
        .scl_drv(scl_drv), .sda_drv(sda_drv));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task results;
        $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One bus cycle; holds the request until waitrequest is seen low
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : acc

    task do_reset;
        rst_b <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
    endtask : do_reset

    // Set up while paused, run one frame, then check pins and registers
    task run_case(input logic [3:0] cfg, input logic [3:0] wac, input logic [7:0] bv,
                  input logic [8:0] ptx, input int n, input logic st,
                  input logic [8:0] eprx, input logic cb, input logic [7:0] eb,
                  input logic [3:0] ew, input logic [3:0] es, input logic eo);
        do_reset();
        acc(1'b1, sswa_pkg::IDX_BUFFER, {24'h000000, bv});
        acc(1'b1, sswa_pkg::IDX_CONFIG, {28'h0000000, cfg});
        acc(1'b1, sswa_pkg::IDX_WAITACK, {28'h0000000, wac});
        u_peer.frame(ptx, n, st, prx);
        // Pin filter and output register settle in a few cycles
        repeat (8) @(posedge ref_clk);
        chk("peer_rx", {23'h000000, eprx}, {23'h000000, prx});
        chk("scl_oe", {31'h00000000, eo}, {31'h00000000, scl_oe});
        acc(1'b0, sswa_pkg::IDX_WAITACK, 32'h00000000);
        chk("wait_ack", {28'h0000000, ew}, q);
        acc(1'b0, sswa_pkg::IDX_STATUS, 32'h00000000);
        chk("count", {28'h0000000, es}, q);
        acc(1'b0, sswa_pkg::IDX_BUFFER, 32'h00000000);
        if (cb) chk("buffer", {24'h000000, eb}, q);
        $display("Case done: %0d checks, %0d mismatches", checks, fail_count);
    endtask : run_case

    // Hang guard: far above the under one thousand cycles the cases need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h00000000;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        acc(1'b0, sswa_pkg::IDX_WAITACK, 32'h00000000);
        chk("wait_ack_reset", 32'h00000000, q);
        acc(1'b1, 4'h3, 32'hFFFFFFFF);
        acc(1'b0, 4'h3, 32'h00000000);
        chk("unmapped", 32'h00000000, q);
        acc(1'b1, sswa_pkg::IDX_STATUS, 32'h0000000F);
        acc(1'b0, sswa_pkg::IDX_STATUS, 32'h00000000);
        chk("status_ro", 32'h00000000, q);
        acc(1'b1, sswa_pkg::IDX_WAITACK, 32'hFFFFFFF4);
        acc(1'b0, sswa_pkg::IDX_WAITACK, 32'h00000000);
        chk("running", 32'h00000004, q);
        chk("scl_free", 32'h00000000, {31'h00000000, scl_oe});
        acc(1'b1, sswa_pkg::IDX_WAITACK, 32'h00000000);
        acc(1'b0, sswa_pkg::IDX_WAITACK, 32'h00000000);
        chk("forced", 32'h00000000, q);
        chk("scl_held", 32'h00000001, {31'h00000000, scl_oe});
        $display("Register test done");
        // Serial receive and transmit, data wait and no wait
        run_case(4'h0, 4'h5, 8'h00, 9'h03C, 8, 1'b0, 9'h03C, 1'b1, 8'h3C, 4'h1, 4'h8, 1'b1);
        run_case(4'h2, 4'h5, 8'hA5, 9'h1FF, 8, 1'b0, 9'h0A5, 1'b1, 8'hA5, 4'h1, 4'h8, 1'b1);
        // No wait: the closing release is a ninth rise, so one more shift and a wrap
        run_case(4'h2, 4'h4, 8'h5A, 9'h1FF, 8, 1'b0, 9'h05A, 1'b1, 8'hB4, 4'h4, 4'h0, 1'b0);
        // Bus mode: drive ack low, capture a peer nack, address wait
        run_case(4'h1, 4'h6, 8'h00, 9'h187, 9, 1'b0, 9'h186, 1'b0, 8'h00, 4'h2, 4'h9, 1'b1);
        run_case(4'h3, 4'h6, 8'h96, 9'h1FF, 9, 1'b0, 9'h12D, 1'b0, 8'h00, 4'hA, 4'h9, 1'b1);
        run_case(4'h1, 4'hF, 8'h00, 9'h0E1, 8, 1'b1, 9'h0E1, 1'b1, 8'hE1, 4'hB, 4'h8, 1'b1);
        results();
    end
endmodule : testbench
